/* File: hw/i2c_seq_cfg.svh */
// constants for the two-wire master sequencing host: offsets, bit positions, status codes
`ifndef I2C_SEQ_CFG_SVH
`define I2C_SEQ_CFG_SVH

// device register port offsets
`define DEV_OFS_DATA   3'h2
`define DEV_OFS_CTL    3'h3
`define DEV_OFS_STAT   3'h4

// control_reg bit positions
`define CTL_ACK_BIT    2
`define CTL_FLAG_BIT   3
`define CTL_STOP_BIT   4
`define CTL_START_BIT  5

// first byte of a 10-bit address carries this header above a9:a8
`define TENBIT_HDR     5'h1e

// status codes read back from status_code_reg
`define ST_START       8'h08
`define ST_RESTART     8'h10
`define ST_AW_ACK      8'h18
`define ST_AW_NACK     8'h20
`define ST_D_ACK       8'h28
`define ST_D_NACK      8'h30
`define ST_ARB         8'h38
`define ST_AR_ACK      8'h40
`define ST_AR_NACK     8'h48
`define ST_RX_ACK      8'h50
`define ST_RX_NACK     8'h58
`define ST_SLV_W       8'h68
`define ST_GCALL       8'h78
`define ST_SLV_R       8'hb0
`define ST_A2_ACK      8'hd0
`define ST_A2_NACK     8'hd8
`define ST_IDLE        8'hf8

// own register map on the AXI4-Lite side
`define AXIL_AW        4
`define AXIL_OFS_CMD   4'h0
`define AXIL_OFS_STAT  4'h4
`define AXIL_OKAY      2'h0
`define AXIL_SLVERR    2'h2

`endif

/* File: hw/i2c_seq_pkg.sv */
// types shared by the sequencing host and its register slave
`include "i2c_seq_cfg.svh"
package i2c_seq_pkg;

  typedef enum logic [2:0] {
    OP_START, OP_ADDR, OP_ADDR2, OP_SEND, OP_RECV, OP_STOP, OP_STOP_START, OP_RELEASE
  } op_t;

  typedef enum logic [2:0] {
    PH_IDLE, PH_CTL_WR, PH_POLL_RQ, PH_POLL_CHK, PH_STAT_RQ, PH_STAT_CHK, PH_DATA_RQ,
    PH_DATA_CHK
  } phase_t;

  typedef struct packed {
    logic [13:0] rsvd;
    logic [9:0]  arg;
    logic [1:0]  pad;
    logic        rd;
    logic        ten;
    logic        ack;
    op_t         op;
  } cmd_word_t;

  typedef struct packed {
    logic [12:0] rsvd;
    logic        refused;
    logic        busy;
    logic        tenbit_open;
    logic [7:0]  rx_data;
    logic [7:0]  code;
  } status_word_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } dev_req_t;

  typedef struct packed {
    phase_t     ph;
    cmd_word_t  cmd;
    logic [7:0] ctl_val;
    dev_req_t   dev;
    logic [7:0] code;
    logic [7:0] rx;
    logic       busy;
    logic       refused;
    logic       tenbit_open;
  } host_st_t;

  typedef struct packed {
    logic                awready;
    logic                wready;
    logic                arready;
    logic                aw_got;
    logic                w_got;
    logic [`AXIL_AW-1:0] awaddr;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [1:0]          rresp;
    logic [31:0]         rdata;
    logic [31:0]         cmd;
    logic                cmd_pulse;
  } axil_st_t;

endpackage : i2c_seq_pkg

/* File: hw/i2c_seq_axil.sv */
// AXI4-Lite slave holding the command word and presenting the status word
`timescale 1ns/100ps
`include "i2c_seq_cfg.svh"
module i2c_seq_axil (
  input  wire logic                     sys_clk,
  input  wire logic                     rst_b,
  input  wire logic [`AXIL_AW-1:0]      s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [`AXIL_AW-1:0]      s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  output logic                          cmd_valid,
  output i2c_seq_pkg::cmd_word_t        cmd_word,
  input  wire i2c_seq_pkg::status_word_t status_word
);
  i2c_seq_pkg::axil_st_t s;
  i2c_seq_pkg::axil_st_t next_s;

  always_comb begin
    next_s = s;
    next_s.cmd_pulse = 1'h0;
    if (s.awready && s_axi_awvalid) begin
      next_s.aw_got  = 1'h1;
      next_s.awaddr  = s_axi_awaddr;
      next_s.awready = 1'h0;
    end
    if (s.wready && s_axi_wvalid) begin
      next_s.w_got  = 1'h1;
      next_s.wdata  = s_axi_wdata;
      next_s.wstrb  = s_axi_wstrb;
      next_s.wready = 1'h0;
    end
    // response only once both halves are in, whichever came first
    if (next_s.aw_got && next_s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'h0;
      next_s.w_got  = 1'h0;
      next_s.bvalid = 1'h1;
      next_s.bresp  = `AXIL_OKAY;
      if (next_s.awaddr == `AXIL_OFS_CMD) begin
        for (int i = 0; i < 4; i++) begin
          if (next_s.wstrb[i]) begin
            next_s.cmd[i*8 +: 8] = next_s.wdata[i*8 +: 8];
          end
        end
        next_s.cmd_pulse = 1'h1;
      end else if (next_s.awaddr != `AXIL_OFS_STAT) begin
        next_s.bresp = `AXIL_SLVERR;
      end
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid  = 1'h0;
      next_s.awready = 1'h1;
      next_s.wready  = 1'h1;
    end
    if (s.arready && s_axi_arvalid) begin
      next_s.arready = 1'h0;
      next_s.rvalid  = 1'h1;
      next_s.rresp   = `AXIL_OKAY;
      next_s.rdata   = 32'h0000_0000;
      if (s_axi_araddr == `AXIL_OFS_CMD) begin
        next_s.rdata = s.cmd;
      end else if (s_axi_araddr == `AXIL_OFS_STAT) begin
        next_s.rdata = status_word;
      end else begin
        next_s.rresp = `AXIL_SLVERR;
      end
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid  = 1'h0;
      next_s.arready = 1'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s         <= '0;
      s.awready <= 1'h1;
      s.wready  <= 1'h1;
      s.arready <= 1'h1;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready  = s.wready;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign s_axi_rvalid  = s.rvalid;
  assign cmd_valid     = s.cmd_pulse;
  assign cmd_word      = s.cmd;
endmodule : i2c_seq_axil

/* File: hw/i2c_seq_host.sv */
// host that drives the two-wire controller's register port one bus step per command
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`include "i2c_seq_cfg.svh"
module i2c_seq_host (
  input  wire logic                sys_clk,
  input  wire logic                rst_b,
  input  wire logic [`AXIL_AW-1:0] s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [`AXIL_AW-1:0] s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output i2c_seq_pkg::dev_req_t    dev_req,
  input  wire logic [7:0]          dev_rdata
);
  i2c_seq_pkg::host_st_t     s;
  i2c_seq_pkg::host_st_t     next_s;
  logic                      cmd_valid;
  i2c_seq_pkg::cmd_word_t    cmd_word;
  i2c_seq_pkg::status_word_t status_word;

  always_comb begin
    status_word             = '0;
    status_word.refused     = s.refused;
    status_word.busy        = s.busy;
    status_word.tenbit_open = s.tenbit_open;
    status_word.rx_data     = s.rx;
    status_word.code        = s.code;
  end

  i2c_seq_axil regs (
    .sys_clk       (sys_clk),
    .rst_b         (rst_b),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .cmd_valid     (cmd_valid),
    .cmd_word      (cmd_word),
    .status_word   (status_word)
  );

  always_comb begin
    logic [7:0] byte_out;
    logic [7:0] ctl;
    logic       refuse;
    logic       stop_op;
    byte_out    = 8'h00;
    ctl         = 8'h00;
    refuse      = 1'h0;
    stop_op     = (cmd_word.op == i2c_seq_pkg::OP_STOP) ||
                  (cmd_word.op == i2c_seq_pkg::OP_STOP_START);
    next_s      = s;
    next_s.dev.rd = 1'h0;
    next_s.dev.wr = 1'h0;
    // flag bit stays 0: every control write is also the flag clear
    ctl[`CTL_START_BIT] = (cmd_word.op == i2c_seq_pkg::OP_START) ||
                          (cmd_word.op == i2c_seq_pkg::OP_STOP_START);
    ctl[`CTL_STOP_BIT]  = stop_op;
    ctl[`CTL_ACK_BIT]   = cmd_word.ack;
    case (cmd_word.op)
      i2c_seq_pkg::OP_ADDR: begin
        if (cmd_word.ten) begin
          byte_out = {`TENBIT_HDR, cmd_word.arg[9:8], cmd_word.rd};
        end else begin
          byte_out = {cmd_word.arg[6:0], cmd_word.rd};
        end
      end
      i2c_seq_pkg::OP_ADDR2,
      i2c_seq_pkg::OP_SEND: byte_out = cmd_word.arg[7:0];
      default:              byte_out = 8'h00;
    endcase
    // a 10-bit read only after the full address went out in write direction
    if (cmd_word.op == i2c_seq_pkg::OP_ADDR && cmd_word.ten && cmd_word.rd &&
        !s.tenbit_open) begin
      refuse = 1'h1;
    end
    // stopping right after an acknowledged byte would leave the slave driving data
    if (stop_op && s.code == `ST_RX_ACK) begin
      refuse = 1'h1;
    end
    case (s.ph)
      i2c_seq_pkg::PH_IDLE: begin
        if (cmd_valid && refuse) begin
          next_s.refused = 1'h1;
        end else if (cmd_valid) begin
          next_s.refused = 1'h0;
          next_s.busy    = 1'h1;
          next_s.cmd     = cmd_word;
          next_s.ctl_val = ctl;
          next_s.ph      = i2c_seq_pkg::PH_CTL_WR;
          if (cmd_word.op == i2c_seq_pkg::OP_ADDR || cmd_word.op == i2c_seq_pkg::OP_ADDR2 ||
              cmd_word.op == i2c_seq_pkg::OP_SEND) begin
            next_s.dev.wr    = 1'h1;
            next_s.dev.addr  = `DEV_OFS_DATA;
            next_s.dev.wdata = byte_out;
          end
        end
      end
      i2c_seq_pkg::PH_CTL_WR: begin
        next_s.dev.wr    = 1'h1;
        next_s.dev.addr  = `DEV_OFS_CTL;
        next_s.dev.wdata = s.ctl_val;
        if (s.cmd.op == i2c_seq_pkg::OP_RELEASE) begin
          next_s.busy = 1'h0;
          next_s.ph   = i2c_seq_pkg::PH_IDLE;
        end else begin
          next_s.ph = i2c_seq_pkg::PH_POLL_RQ;
        end
      end
      i2c_seq_pkg::PH_POLL_RQ: begin
        next_s.dev.rd   = 1'h1;
        next_s.dev.addr = `DEV_OFS_CTL;
        next_s.ph       = i2c_seq_pkg::PH_POLL_CHK;
      end
      i2c_seq_pkg::PH_POLL_CHK: begin
        // the device self-clears its stop bit instead of raising the flag
        if (s.cmd.op == i2c_seq_pkg::OP_STOP ? !dev_rdata[`CTL_STOP_BIT]
                                            : dev_rdata[`CTL_FLAG_BIT]) begin
          next_s.ph = i2c_seq_pkg::PH_STAT_RQ;
        end else begin
          next_s.ph = i2c_seq_pkg::PH_POLL_RQ;
        end
      end
      i2c_seq_pkg::PH_STAT_RQ: begin
        next_s.dev.rd   = 1'h1;
        next_s.dev.addr = `DEV_OFS_STAT;
        next_s.ph       = i2c_seq_pkg::PH_STAT_CHK;
      end
      i2c_seq_pkg::PH_STAT_CHK: begin
        next_s.code = dev_rdata;
        if (dev_rdata == `ST_A2_ACK) begin
          next_s.tenbit_open = 1'h1;
        end else if (dev_rdata == `ST_ARB || dev_rdata == `ST_IDLE ||
                     s.cmd.op == i2c_seq_pkg::OP_STOP) begin
          next_s.tenbit_open = 1'h0;
        end
        if (s.cmd.op == i2c_seq_pkg::OP_RECV) begin
          next_s.ph = i2c_seq_pkg::PH_DATA_RQ;
        end else begin
          next_s.busy = 1'h0;
          next_s.ph   = i2c_seq_pkg::PH_IDLE;
        end
      end
      i2c_seq_pkg::PH_DATA_RQ: begin
        next_s.dev.rd   = 1'h1;
        next_s.dev.addr = `DEV_OFS_DATA;
        next_s.ph       = i2c_seq_pkg::PH_DATA_CHK;
      end
      i2c_seq_pkg::PH_DATA_CHK: begin
        next_s.rx   = dev_rdata;
        next_s.busy = 1'h0;
        next_s.ph   = i2c_seq_pkg::PH_IDLE;
      end
      default: next_s.ph = i2c_seq_pkg::PH_IDLE;
    endcase
    // a command while busy is dropped, never queued
    if (cmd_valid && s.ph != i2c_seq_pkg::PH_IDLE) begin
      next_s.refused = 1'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s      <= '0;
      s.code <= `ST_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign dev_req = s.dev;

  property p_reset_code;
    @(posedge sys_clk) $rose(rst_b) |-> s.code == `ST_IDLE && !s.busy;
  endproperty
  a_reset_code: assert property (p_reset_code) else $error("status not F8h after reset");

  property p_hold_while_flag;
    @(posedge sys_clk) disable iff (!rst_b)
      s.ph == i2c_seq_pkg::PH_POLL_CHK && s.cmd.op != i2c_seq_pkg::OP_STOP &&
      !dev_rdata[`CTL_FLAG_BIT] |-> !s.dev.wr ##1 s.ph == i2c_seq_pkg::PH_POLL_RQ;
  endproperty
  a_hold_while_flag: assert property (p_hold_while_flag)
    else $error("advanced without flag");

  property p_read_addr_lsb;
    @(posedge sys_clk) disable iff (!rst_b)
      s.ph == i2c_seq_pkg::PH_IDLE && cmd_valid && cmd_word.op == i2c_seq_pkg::OP_ADDR &&
      !cmd_word.ten |=> s.dev.wr && s.dev.addr == `DEV_OFS_DATA &&
      s.dev.wdata[0] == $past(cmd_word.rd) ##1 s.dev.wr && s.dev.addr == `DEV_OFS_CTL &&
      !s.dev.wdata[`CTL_FLAG_BIT];
  endproperty
  a_read_addr_lsb: assert property (p_read_addr_lsb) else $error("address lsb wrong");

  property p_tenbit_read_refused;
    @(posedge sys_clk) disable iff (!rst_b)
      s.ph == i2c_seq_pkg::PH_IDLE && cmd_valid && cmd_word.op == i2c_seq_pkg::OP_ADDR &&
      cmd_word.ten && cmd_word.rd && !s.tenbit_open |=> s.refused && !s.busy && !s.dev.wr;
  endproperty
  a_tenbit_read_refused: assert property (p_tenbit_read_refused)
    else $error("10-bit read");

  property p_stop_after_ack_refused;
    @(posedge sys_clk) disable iff (!rst_b)
      s.ph == i2c_seq_pkg::PH_IDLE && cmd_valid && s.code == `ST_RX_ACK &&
      cmd_word.op == i2c_seq_pkg::OP_STOP |=> s.refused ##1 !s.dev.wr;
  endproperty
  a_stop_after_ack_refused: assert property (p_stop_after_ack_refused)
    else $error("stop on 50h");

  property p_stop_waits_clear;
    @(posedge sys_clk) disable iff (!rst_b)
      s.ph == i2c_seq_pkg::PH_POLL_CHK && s.cmd.op == i2c_seq_pkg::OP_STOP &&
      dev_rdata[`CTL_STOP_BIT] |=> s.ph == i2c_seq_pkg::PH_POLL_RQ && s.busy;
  endproperty
  a_stop_waits_clear: assert property (p_stop_waits_clear) else $error("stop left early");

  property p_both_bits;
    @(posedge sys_clk) disable iff (!rst_b)
      s.dev.wr && s.dev.addr == `DEV_OFS_CTL && s.cmd.op == i2c_seq_pkg::OP_STOP_START |->
      s.dev.wdata[`CTL_STOP_BIT] && s.dev.wdata[`CTL_START_BIT] && !s.dev.wdata[`CTL_FLAG_BIT];
  endproperty
  a_both_bits: assert property (p_both_bits) else $error("stop-start bits wrong");

  property p_ack_choice;
    @(posedge sys_clk) disable iff (!rst_b)
      s.dev.wr && s.dev.addr == `DEV_OFS_CTL |->
      s.dev.wdata[`CTL_ACK_BIT] == s.cmd.ack &&
      s.dev.wdata[`CTL_START_BIT] == (s.cmd.op == i2c_seq_pkg::OP_START ||
                                      s.cmd.op == i2c_seq_pkg::OP_STOP_START);
  endproperty
  a_ack_choice: assert property (p_ack_choice) else $error("control byte wrong");

  property p_release_idles;
    @(posedge sys_clk) disable iff (!rst_b)
      s.ph == i2c_seq_pkg::PH_CTL_WR && s.cmd.op == i2c_seq_pkg::OP_RELEASE |=>
      s.ph == i2c_seq_pkg::PH_IDLE && !s.busy && s.dev.wr;
  endproperty
  a_release_idles: assert property (p_release_idles) else $error("release did not idle");

  property p_recv_data;
    @(posedge sys_clk) disable iff (!rst_b)
      s.ph == i2c_seq_pkg::PH_DATA_CHK |=> s.rx == $past(dev_rdata) && !s.busy;
  endproperty
  a_recv_data: assert property (p_recv_data) else $error("received byte lost");

  property p_busy_drops;
    @(posedge sys_clk) disable iff (!rst_b)
      s.ph != i2c_seq_pkg::PH_IDLE && cmd_valid
      |=> s.refused && s.cmd == $past(s.cmd);
  endproperty
  a_busy_drops: assert property (p_busy_drops)
    else $error("command taken while busy");

  property p_stop_closes_tenbit;
    @(posedge sys_clk) disable iff (!rst_b)
      s.ph == i2c_seq_pkg::PH_STAT_CHK &&
      s.cmd.op == i2c_seq_pkg::OP_STOP |=> !s.tenbit_open;
  endproperty
  a_stop_closes_tenbit: assert property (p_stop_closes_tenbit)
    else $error("10-bit mode left open");

  property p_ctl_clears_flag;
    @(posedge sys_clk) disable iff (!rst_b)
      s.dev.wr && s.dev.addr == `DEV_OFS_CTL |->
      !s.dev.wdata[`CTL_FLAG_BIT];
  endproperty
  a_ctl_clears_flag: assert property (p_ctl_clears_flag)
    else $error("flag not cleared");

  property p_cov_recv;
    @(posedge sys_clk) disable iff (!rst_b) s.ph == i2c_seq_pkg::PH_DATA_CHK;
  endproperty
  c_cov_recv: cover property (p_cov_recv);

  property p_cov_tenbit;
    @(posedge sys_clk) disable iff (!rst_b) $rose(s.tenbit_open);
  endproperty
  c_cov_tenbit: cover property (p_cov_tenbit);

  property p_cov_refused;
    @(posedge sys_clk) disable iff (!rst_b) $rose(s.refused);
  endproperty
  c_cov_refused: cover property (p_cov_refused);

  property p_cov_stop;
    @(posedge sys_clk) disable iff (!rst_b)
      s.ph == i2c_seq_pkg::PH_POLL_CHK && s.cmd.op == i2c_seq_pkg::OP_STOP;
  endproperty
  c_cov_stop: cover property (p_cov_stop);

  property p_cov_drop;
    @(posedge sys_clk) disable iff (!rst_b)
      s.ph != i2c_seq_pkg::PH_IDLE && cmd_valid;
  endproperty
  c_cov_drop: cover property (p_cov_drop);
endmodule : i2c_seq_host

/* File: test/i2c_dev_model.sv */
// behavioural model of the two-wire controller's register port
`timescale 1ns/100ps
`include "i2c_seq_cfg.svh"
module i2c_dev_model (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire i2c_seq_pkg::dev_req_t dev_req,
  output logic [7:0]                 dev_rdata,
  input  wire logic [7:0]            next_code,
  input  wire logic [7:0]            rx_byte,
  input  wire logic                  slow,
  output logic [7:0]                 ctl,
  output logic [7:0]                 data
);
  logic [7:0] status;
  logic [7:0] last_out;
  logic [3:0] cnt;
  // an idle read port shows the inverse of its last value, so stale reads cannot pass
  always_comb begin
    dev_rdata = ~last_out;
    if (dev_req.rd && dev_req.addr == `DEV_OFS_DATA) dev_rdata = rx_byte;
    if (dev_req.rd && dev_req.addr == `DEV_OFS_CTL) dev_rdata = ctl;
    if (dev_req.rd && dev_req.addr == `DEV_OFS_STAT) dev_rdata = status;
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctl <= 8'h00;
      data <= 8'h00;
      status <= `ST_IDLE;
      cnt <= 4'h0;
      last_out <= 8'h00;
    end else begin
      if (dev_req.rd) last_out <= dev_rdata;
      if (dev_req.wr && dev_req.addr == `DEV_OFS_DATA) data <= dev_req.wdata;
      if (dev_req.wr && dev_req.addr == `DEV_OFS_CTL) begin
        ctl <= dev_req.wdata;
        // clock held low, nothing moves while the flag stands; slow step is 12 cycles
        if (!dev_req.wdata[`CTL_FLAG_BIT]) cnt <= slow ? 4'hc : 4'h2;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
        if (cnt == 4'h1 && ctl[`CTL_STOP_BIT] && !ctl[`CTL_START_BIT]) begin
          ctl[`CTL_STOP_BIT] <= 1'b0;
          status <= `ST_IDLE;
        end else if (cnt == 4'h1 && !ctl[`CTL_START_BIT] && status == `ST_ARB) begin
          status <= `ST_IDLE;
        end else if (cnt == 4'h1) begin
          ctl[`CTL_FLAG_BIT] <= 1'b1;
          ctl[`CTL_STOP_BIT] <= 1'b0;
          status <= next_code;
        end
      end
    end
  end
endmodule : i2c_dev_model

/* File: test/tb_i2c_seq_host.sv */
// self-checking bench for the two-wire sequencing host
`timescale 1ns/100ps
`include "i2c_seq_cfg.svh"
`define CHK(g, e) check(32'(g), 32'(e))
module tb_i2c_seq_host;
  logic                      sys_clk = 1'b0;
  logic                      rst_b = 1'b0;
  logic [`AXIL_AW-1:0]       s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]               s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]                s_axi_wstrb = 4'hf;
  logic                      s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                      s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, slow = 1'b0;
  logic                      s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic                      s_axi_arready, s_axi_rvalid;
  logic [1:0]                s_axi_bresp, s_axi_rresp;
  logic [7:0]                dev_rdata, ctl, data, next_code = '0, rx_byte = '0;
  i2c_seq_pkg::dev_req_t     dev_req;
  i2c_seq_pkg::status_word_t sw;
  int                        mismatches = 0, n_checks = 0;

  i2c_seq_host i_i2c_seq_host (.sys_clk(sys_clk), .rst_b(rst_b),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .dev_req(dev_req),
    .dev_rdata(dev_rdata));
  i2c_dev_model i_i2c_dev_model (.sys_clk(sys_clk), .rst_b(rst_b), .dev_req(dev_req),
    .dev_rdata(dev_rdata), .next_code(next_code), .rx_byte(rx_byte), .slow(slow),
    .ctl(ctl), .data(data));

  always #4 sys_clk = ~sys_clk;

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check

  // helpers return one edge after the answer so no strobe toggles twice in a step
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask : axi_rd

  task automatic wait_idle();
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 60; i++) begin
      axi_rd(`AXIL_OFS_STAT, d, r);
      sw = d;
      if (sw.busy === 1'b0) break;
    end
    `CHK(sw.busy, 1'b0);
  endtask : wait_idle

  task automatic run(input i2c_seq_pkg::op_t op, input logic [9:0] arg,
                     input logic [2:0] f, input logic [7:0] code);
    i2c_seq_pkg::cmd_word_t cw;
    logic [1:0]             r;
    cw = '0;
    cw.op = op;
    cw.arg = arg;
    {cw.rd, cw.ten, cw.ack} = f;
    next_code <= code;
    axi_wr(`AXIL_OFS_CMD, cw, r);
    wait_idle();
  endtask : run

  task automatic t_tx7();
    run(i2c_seq_pkg::OP_START, 10'h000, 3'b000, `ST_START);
    `CHK({sw.code, ctl[`CTL_START_BIT]}, {`ST_START, 1'b1});
    run(i2c_seq_pkg::OP_ADDR, 10'h050, 3'b000, `ST_AW_ACK);
    `CHK({sw.code, data}, {`ST_AW_ACK, 8'ha0});
    run(i2c_seq_pkg::OP_SEND, 10'h05a, 3'b000, `ST_D_ACK);
    `CHK({sw.code, data}, {`ST_D_ACK, 8'h5a});
    slow <= 1'b1;
    run(i2c_seq_pkg::OP_SEND, 10'h0c3, 3'b000, `ST_D_NACK);
    `CHK({sw.code, data, sw.busy}, {`ST_D_NACK, 8'hc3, 1'b0});
    slow <= 1'b0;
    run(i2c_seq_pkg::OP_STOP_START, 10'h000, 3'b000, `ST_RESTART);
    `CHK({sw.code, ctl[`CTL_START_BIT]}, {`ST_RESTART, 1'b1});
    run(i2c_seq_pkg::OP_STOP, 10'h000, 3'b000, 8'h00);
    `CHK({sw.code, ctl[`CTL_STOP_BIT]}, {`ST_IDLE, 1'b0});
  endtask : t_tx7

  task automatic t_tenbit();
    run(i2c_seq_pkg::OP_START, 10'h000, 3'b000, `ST_START);
    run(i2c_seq_pkg::OP_ADDR, 10'h2a5, 3'b110, `ST_AR_ACK);
    `CHK({sw.refused, sw.busy, sw.code}, {2'b10, `ST_START});
    run(i2c_seq_pkg::OP_ADDR, 10'h2a5, 3'b010, `ST_AW_ACK);
    `CHK({sw.code, data, sw.refused}, {`ST_AW_ACK, 8'hf4, 1'b0});
    run(i2c_seq_pkg::OP_ADDR2, 10'h2a5, 3'b010, `ST_A2_ACK);
    `CHK({sw.code, data, sw.tenbit_open}, {`ST_A2_ACK, 8'ha5, 1'b1});
    run(i2c_seq_pkg::OP_START, 10'h000, 3'b000, `ST_RESTART);
    run(i2c_seq_pkg::OP_ADDR, 10'h2a5, 3'b110, `ST_AR_ACK);
    `CHK({sw.code, data, sw.refused}, {`ST_AR_ACK, 8'hf5, 1'b0});
    rx_byte <= 8'h3c;
    run(i2c_seq_pkg::OP_RECV, 10'h000, 3'b001, `ST_RX_ACK);
    `CHK({sw.code, sw.rx_data, ctl[`CTL_ACK_BIT]}, {`ST_RX_ACK, 8'h3c, 1'b1});
    run(i2c_seq_pkg::OP_STOP, 10'h000, 3'b000, 8'h00);
    `CHK({sw.refused, sw.code}, {1'b1, `ST_RX_ACK});
    rx_byte <= 8'h81;
    run(i2c_seq_pkg::OP_RECV, 10'h000, 3'b000, `ST_RX_NACK);
    `CHK({sw.code, sw.rx_data, ctl[`CTL_ACK_BIT]}, {`ST_RX_NACK, 8'h81, 1'b0});
    run(i2c_seq_pkg::OP_STOP, 10'h000, 3'b000, 8'h00);
    `CHK({sw.code, sw.tenbit_open, sw.refused}, {`ST_IDLE, 2'b00});
  endtask : t_tenbit

  task automatic t_arb();
    logic [7:0] codes [5];
    codes = '{`ST_SLV_W, `ST_GCALL, `ST_SLV_R, `ST_A2_NACK, `ST_AR_NACK};
    run(i2c_seq_pkg::OP_START, 10'h000, 3'b000, `ST_START);
    run(i2c_seq_pkg::OP_ADDR, 10'h011, 3'b000, `ST_ARB);
    run(i2c_seq_pkg::OP_RELEASE, 10'h000, 3'b000, 8'h00);
    `CHK({sw.busy, ctl[`CTL_FLAG_BIT], ctl[`CTL_START_BIT]}, 3'b000);
    slow <= 1'b1;
    run(i2c_seq_pkg::OP_START, 10'h000, 3'b000, `ST_START);
    `CHK(sw.code, `ST_START);
    slow <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      run(i2c_seq_pkg::OP_RECV, 10'h000, 3'(i % 2), codes[i]);
      `CHK({sw.code, ctl[`CTL_ACK_BIT]}, {codes[i], 1'(i % 2)});
    end
    run(i2c_seq_pkg::OP_RECV, 10'h000, 3'b000, `ST_ARB);
    `CHK({sw.code, sw.tenbit_open}, {`ST_ARB, 1'b0});
    run(i2c_seq_pkg::OP_RELEASE, 10'h000, 3'b000, 8'h00);
  endtask : t_arb

  task automatic t_bus();
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(`AXIL_OFS_STAT, d, r);
    `CHK({d[17], d[7:0], r}, {1'b0, `ST_IDLE, `AXIL_OKAY});
    axi_wr(4'h8, 32'h0000_0005, r);
    `CHK(r, `AXIL_SLVERR);
    axi_rd(4'hc, d, r);
    `CHK({r, d}, {`AXIL_SLVERR, 32'h0000_0000});
  endtask : t_bus

  task automatic t_busy();
    logic [1:0] r;
    slow <= 1'b1;
    next_code <= `ST_START;
    axi_wr(`AXIL_OFS_CMD, 32'(i2c_seq_pkg::OP_START), r);
    axi_wr(`AXIL_OFS_CMD, 32'(i2c_seq_pkg::OP_STOP), r);
    wait_idle();
    `CHK({sw.code, sw.refused}, {`ST_START, 1'b1});
  endtask : t_busy

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  initial begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_bus();
    t_tx7();
    t_tenbit();
    t_arb();
    t_busy();
    conclude();
  end

  // a few thousand cycles suffice; this only catches a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    conclude();
  end
endmodule : tb_i2c_seq_host
